// [rtl/qbt_pkg.sv]
// shared types and constants for the quad bus transceiver slice
package qbt_pkg;
   localparam int unsigned WIDTH = 4;

   // every pin input of the slice, carried through the synchroniser as one word
   typedef struct packed {
      logic             driver_reg_clock;
      logic             bus_drive_enable_n;
      logic             receiver_latch_enable_n;
      logic             receiver_output_enable_n;
      logic [WIDTH-1:0] data;
      logic [WIDTH-1:0] bus;
   } qbt_pin_type;

   localparam int unsigned PIN_BITS = 4 + 2 * WIDTH;

   // reset levels: clock low, enables inactive, data zero, bus released high
   localparam logic [PIN_BITS-1:0] PIN_IDLE  = 12'h70F;
   localparam logic [WIDTH-1:0]    DRV_RESET = 4'h0;
   localparam logic [WIDTH-1:0]    LAT_RESET = 4'h0;
   localparam logic [WIDTH-1:0]    ALL_ZERO  = 4'h0;
   localparam logic                BIT_RESET = 1'h0;

   function automatic logic qbt_parity(input logic [WIDTH-1:0] word);
      qbt_parity = ^word;
   endfunction
endpackage

// [rtl/qbt_transceiver.sv]
// quad open-collector bus transceiver slice with driver register, receiver latch and parity
//
// Notes on behaviour
// - On each rising edge of the driver register clock the four data inputs are stored.
// - With the driver register clock steady, the driver register keeps its value.
// - With bus drive enable low, each bus line carries the inverse of its driver bit.
// - With bus drive enable high, all four bus lines are released and only received.
// - With receiver latch enable low, each latch bit follows the inverse of its bus line.
// - With receiver latch enable high, the latch holds its contents whatever else changes.
// - Receiver outputs float while output enable is high and show the latch while it is low.
// - Bus to receiver output is inverted, so driver input to receiver output is not.
// - With bus drive enable low, parity output is the XOR of the four data inputs.
// - With bus drive enable high, parity output is the XOR of the four latch bits.
`timescale 1ns/1ps
module qbt_transceiver (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   // driver side pins
   input  wire logic                      driver_reg_clock,
   input  wire logic [qbt_pkg::WIDTH-1:0] data_in,
   input  wire logic                      bus_drive_enable_n,
   // open-collector bus, level seen and pull-low enable
   input  wire logic [qbt_pkg::WIDTH-1:0] bus_in,
   output logic      [qbt_pkg::WIDTH-1:0] bus_pull_low,
   // receiver side pins
   input  wire logic                      receiver_latch_enable_n,
   input  wire logic                      receiver_output_enable_n,
   output logic      [qbt_pkg::WIDTH-1:0] receiver_out,
   output logic                           receiver_out_oe,
   // parity
   output logic                           odd_parity
);

   qbt_pkg::qbt_pin_type             pin_raw;
   qbt_pkg::qbt_pin_type             sync1;
   qbt_pkg::qbt_pin_type             sync2;
   qbt_pkg::qbt_pin_type             sync3;
   qbt_pkg::qbt_pin_type             pin_f;
   logic                             drv_clk_prev;
   logic [qbt_pkg::WIDTH-1:0]        drv_reg;
   logic [qbt_pkg::WIDTH-1:0]        rx_latch;
   logic                             drv_clk_rise;

   assign pin_raw = '{driver_reg_clock:         driver_reg_clock,
                      bus_drive_enable_n:       bus_drive_enable_n,
                      receiver_latch_enable_n:  receiver_latch_enable_n,
                      receiver_output_enable_n: receiver_output_enable_n,
                      data:                     data_in,
                      bus:                      bus_in};

   // three stages; a change is taken only once stages two and three agree, rejecting
   // single-cycle glitches at the price of one more cycle of latency
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= qbt_pkg::PIN_IDLE;
         sync2 <= qbt_pkg::PIN_IDLE;
         sync3 <= qbt_pkg::PIN_IDLE;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_f <= qbt_pkg::PIN_IDLE;
      end else if (sync2 == sync3) begin
         pin_f <= sync3;
      end
   end

   // edge found on the filtered level; prev resets to the idle low level,
   // so a release of reset with the pin low gives no false load
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         drv_clk_prev <= qbt_pkg::BIT_RESET;
      end else begin
         drv_clk_prev <= pin_f.driver_reg_clock;
      end
   end

   assign drv_clk_rise = pin_f.driver_reg_clock & ~drv_clk_prev;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         drv_reg <= qbt_pkg::DRV_RESET;
      end else if (drv_clk_rise) begin
         drv_reg <= pin_f.data;
      end
   end

   // never driven high: the far side's pull-up makes the high level
   // stored one pulls low, released when disabled
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_pull_low <= qbt_pkg::ALL_ZERO;
      end else if (!pin_f.bus_drive_enable_n) begin
         bus_pull_low <= drv_reg;
      end else begin
         bus_pull_low <= qbt_pkg::ALL_ZERO;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_latch <= qbt_pkg::LAT_RESET;
      end else if (!pin_f.receiver_latch_enable_n) begin
         rx_latch <= ~pin_f.bus;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         receiver_out    <= qbt_pkg::LAT_RESET;
         receiver_out_oe <= qbt_pkg::BIT_RESET;
      end else begin
         receiver_out    <= rx_latch;
         receiver_out_oe <= ~pin_f.receiver_output_enable_n;
      end
   end

   // drive mode reads the data pins, not the stored word, so parity leads the bus
   // generate or check
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         odd_parity <= qbt_pkg::BIT_RESET;
      end else if (!pin_f.bus_drive_enable_n) begin
         odd_parity <= qbt_pkg::qbt_parity(pin_f.data);
      end else begin
         odd_parity <= qbt_pkg::qbt_parity(rx_latch);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // checks look at the filtered pin view, which is what the logic acts on

   drv_load_a: assert property (drv_clk_rise |=> drv_reg == $past(pin_f.data))
      else $error("driver register missed a load");

   drv_hold_a: assert property (!drv_clk_rise |=> $stable(drv_reg))
      else $error("driver register changed without clock edge");

   drv_high_a: assert property (pin_f.driver_reg_clock && drv_clk_prev |=>
                                $stable(drv_reg))
      else $error("driver register changed while clock stayed high");

   bus_drive_a: assert property (!pin_f.bus_drive_enable_n |=> bus_pull_low == $past(drv_reg))
      else $error("bus not driven from driver register");

   pull_stored_a: assert property (##1 ((bus_pull_low & ~$past(drv_reg)) == 4'h0))
      else $error("bus line pulled low for a stored zero");

   bus_release_a: assert property (pin_f.bus_drive_enable_n |=> bus_pull_low == 4'h0)
      else $error("bus not released");

   latch_follow_a: assert property (!pin_f.receiver_latch_enable_n |=>
                                    rx_latch == ~$past(pin_f.bus))
      else $error("open latch not following bus");

   latch_hold_a: assert property (pin_f.receiver_latch_enable_n |=> $stable(rx_latch))
      else $error("closed latch changed");

   rx_out_a: assert property (##1 (receiver_out_oe == !$past(pin_f.receiver_output_enable_n))
                              && (receiver_out == $past(rx_latch)))
      else $error("receiver output or enable wrong");

   rx_float_a: assert property (pin_f.receiver_output_enable_n |=> !receiver_out_oe)
      else $error("receiver outputs driven while disabled");

   rx_drive_a: assert property (!pin_f.receiver_output_enable_n |=> receiver_out_oe)
      else $error("receiver outputs floating while enabled");

   bus_to_rx_a: assert property (!pin_f.receiver_latch_enable_n |=> ##1
                                 receiver_out == ~$past(pin_f.bus, 2))
      else $error("bus to receiver path not inverted");

   parity_gen_a: assert property (!pin_f.bus_drive_enable_n |=>
                                  odd_parity == ^$past(pin_f.data))
      else $error("generated parity wrong");

   parity_chk_a: assert property (pin_f.bus_drive_enable_n |=>
                                  odd_parity == ^$past(rx_latch))
      else $error("checked parity wrong");

   parity_keep_a: assert property ((pin_f.receiver_latch_enable_n &&
                                    pin_f.bus_drive_enable_n) ##1 pin_f.bus_drive_enable_n
                                   |=> $stable(odd_parity))
      else $error("checked parity moved while latch closed");

   pull_cause_a: assert property ((|bus_pull_low) |-> !$past(pin_f.bus_drive_enable_n))
      else $error("bus pulled low while disabled");

   drive_cov: cover property (drv_clk_rise ##1 !pin_f.bus_drive_enable_n ##1 (|bus_pull_low));
   recv_cov: cover property (!pin_f.receiver_latch_enable_n ##1 pin_f.receiver_latch_enable_n
                             ##1 receiver_out_oe);
   parity_cov: cover property (pin_f.bus_drive_enable_n ##1 odd_parity);
   hold_cov: cover property (drv_clk_rise ##1 (pin_f.driver_reg_clock && drv_clk_prev));
   float_cov: cover property (receiver_out_oe ##1 !receiver_out_oe);

endmodule

// [testbench/qbt_bus_agent.sv]
// second agent on the open-collector bus, with the pull-up that resolves it
`timescale 1ns/1ps
module qbt_bus_agent (
   // pull-low requests of the slice and of this agent
   input  wire logic [qbt_pkg::WIDTH-1:0] dev_pull_low,
   input  wire logic [qbt_pkg::WIDTH-1:0] own_pull_low,
   // resolved level of each line
   output logic      [qbt_pkg::WIDTH-1:0] bus_level
);
   // wired-AND lines
   // any agent pulling wins, so a released line reads high
   assign bus_level = ~(dev_pull_low | own_pull_low);
endmodule

// [testbench/qbt_transceiver_bench.sv]
// self-checking bench for the quad bus transceiver slice
`timescale 1ns/1ps
module qbt_transceiver_bench;
   logic       clk_sys;
   logic       arst_n;
   logic       driver_reg_clock;
   logic [3:0] data_in;
   logic       bus_drive_enable_n;
   logic       receiver_latch_enable_n;
   logic       receiver_output_enable_n;
   logic [3:0] own_pull_low;
   logic [3:0] bus_level;
   logic [3:0] bus_pull_low;
   logic [3:0] receiver_out;
   logic       receiver_out_oe;
   logic       odd_parity;
   int         n_fail = 0;
   int         num_checks = 0;
   int         cycles = 0;

   qbt_transceiver uut (.clk_sys(clk_sys), .arst_n(arst_n), .driver_reg_clock(driver_reg_clock),
      .data_in(data_in), .bus_drive_enable_n(bus_drive_enable_n), .bus_in(bus_level),
      .bus_pull_low(bus_pull_low), .receiver_latch_enable_n(receiver_latch_enable_n),
      .receiver_output_enable_n(receiver_output_enable_n), .receiver_out(receiver_out),
      .receiver_out_oe(receiver_out_oe), .odd_parity(odd_parity));
   qbt_bus_agent agent (.dev_pull_low(bus_pull_low), .own_pull_low(own_pull_low),
      .bus_level(bus_level));

   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // run needs about 275 cycles, so 1000 means a hang
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // two filtered hops (release, then the bus level back) need about eleven cycles
   task automatic settle();
      repeat (16) @(negedge clk_sys);
   endtask

   task automatic t_drive(input logic [3:0] word);
      data_in = word;
      bus_drive_enable_n = 1'h0;
      receiver_latch_enable_n = 1'h0;
      receiver_output_enable_n = 1'h0;
      settle();
      driver_reg_clock = 1'h1;
      settle();
      driver_reg_clock = 1'h0;
      settle();
      check("pull low", bus_pull_low, word); // stored word
      check("bus", bus_level, ~word); // inverted drive
      check("receiver", receiver_out, word); // net non-inverted
      check("parity gen", {3'h0, odd_parity}, {3'h0, ^word}); // data parity
      data_in = ~word;
      settle();
      check("held", bus_pull_low, word); // no clock edge
   endtask

   task automatic t_receive();
      bus_drive_enable_n = 1'h1;
      own_pull_low = 4'h6;
      settle();
      check("release", bus_pull_low, 4'h0); // released lines
      check("latch", receiver_out, 4'h6); // transparent latch
      check("parity chk", {3'h0, odd_parity}, 4'h0); // even word
      own_pull_low = 4'h7;
      settle();
      check("parity chk", {3'h0, odd_parity}, 4'h1); // odd word
      receiver_latch_enable_n = 1'h1;
      settle();
      own_pull_low = 4'h1;
      settle();
      check("latch hold", receiver_out, 4'h7); // closed latch
      check("parity hold", {3'h0, odd_parity}, 4'h1); // latched word
      check("oe on", {3'h0, receiver_out_oe}, 4'h1); // driven outputs
      receiver_output_enable_n = 1'h1;
      settle();
      check("oe off", {3'h0, receiver_out_oe}, 4'h0); // floating outputs
      own_pull_low = 4'h0;
   endtask

   // a reset in mid-run must clear the stored word
   task automatic t_reset();
      bus_drive_enable_n = 1'h0;
      settle();
      check("drive before reset", bus_pull_low, 4'hE); // stored word
      arst_n = 1'h0;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'h1;
      settle();
      check("drive after reset", bus_level, 4'hF); // stored zeros high
      check("parity after reset", {3'h0, odd_parity}, 4'h1); // data parity
   endtask

   initial begin
      arst_n = 1'h0;
      driver_reg_clock = 1'h0;
      data_in = 4'h0;
      bus_drive_enable_n = 1'h1;
      receiver_latch_enable_n = 1'h1;
      receiver_output_enable_n = 1'h1;
      own_pull_low = 4'h0;
      repeat (16) @(negedge clk_sys);
      arst_n = 1'h1;
      settle();
      check("idle", {receiver_out_oe, odd_parity, 2'h0}, 4'h0); // quiet outputs
      t_drive(4'h5);
      t_drive(4'hE);
      t_receive();
      t_reset();
      print_verdict();
   end
endmodule
